/* File: include/ato_pkg.sv */
// constants and types for the accumulator transfer execution block
package ato_pkg;
    // datapath widths
    localparam int ACC_W = 4;
    localparam int OP_W = 10;
    localparam int DP_W = 8;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;

    // opcodes of the covered single-word transfers
    localparam logic [OP_W-1:0] OP_LOAD_WAKE_CTL = 10'h215;
    localparam logic [OP_W-1:0] OP_LOAD_CLK_CTL = 10'h216;
    localparam logic [OP_W-1:0] OP_LOAD_PULLUP_CTL0 = 10'h22d;
    // store: upper six bits fixed, low four bits carry the immediate
    localparam logic [OP_W-1:0] OP_STORE_MEM_XOR_FILE = 10'h2b0;
    localparam logic [OP_W-1:0] OP_STORE_MASK = 10'h3f0;
    localparam int IMM_LSB = 0;

    // register byte offsets
    localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_WAKE = 8'h04;
    localparam logic [APB_AW-1:0] OFS_CLK = 8'h08;
    localparam logic [APB_AW-1:0] OFS_PULLUP0 = 8'h0c;
    localparam logic [APB_AW-1:0] OFS_FILE = 8'h10;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h14;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_LAST_LSB = 0;
    localparam int ST_COUNT_LSB = 8;

    // reset values
    localparam logic RST_CTRL_EN = 1'b1;
    localparam logic [ACC_W-1:0] RST_WAKE = 4'h0;
    localparam logic [ACC_W-1:0] RST_CLK = 4'h0;
    localparam logic [ACC_W-1:0] RST_PULLUP0 = 4'h0;
    localparam logic [ACC_W-1:0] RST_FILE = 4'h0;

    // which transfer ran last
    typedef enum logic [2:0]
    {
        ATO_OP_NONE = 3'b000,
        ATO_OP_WAKE = 3'b001,
        ATO_OP_STORE = 3'b010,
        ATO_OP_CLK = 3'b011,
        ATO_OP_PULLUP0 = 3'b100
    } ato_op_e;
endpackage : ato_pkg

/* File: hdl/ato_core.sv */
// execution logic for accumulator-to-register and accumulator-to-memory transfers
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// - wake opcode copies accumulator into wake control
// - store opcode writes accumulator at data pointer
// - store also xors file register with immediate, in the same cycle
// - any immediate 0..15, result kept in file
// - clock opcode loads accumulator into clock control
// - pull-up opcode loads accumulator into pull-up control
module ato_core
    import ato_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // instruction from the core, one word per cycle
    input wire logic INSTR_VALID,
    input wire logic [ato_pkg::OP_W-1:0] INSTR,
    input wire logic [ato_pkg::ACC_W-1:0] ACC,
    input wire logic [ato_pkg::DP_W-1:0] DATA_POINTER,
    // peripheral control registers
    output logic [ato_pkg::ACC_W-1:0] WAKE_CTL,
    output logic [ato_pkg::ACC_W-1:0] CLK_CTL,
    output logic [ato_pkg::ACC_W-1:0] PULLUP_CTL0,
    output logic [ato_pkg::ACC_W-1:0] FILE_REG,
    // ram write port
    output logic MEM_WE,
    output logic [ato_pkg::DP_W-1:0] MEM_ADDR,
    output logic [ato_pkg::ACC_W-1:0] MEM_WDATA,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ato_pkg::APB_AW-1:0] PADDR,
    input wire logic [ato_pkg::APB_DW-1:0] PWDATA,
    output logic [ato_pkg::APB_DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import ato_pkg::*;

    typedef struct packed
    {
        logic en;
        logic [ACC_W-1:0] wake_ctl;
        logic [ACC_W-1:0] clk_ctl;
        logic [ACC_W-1:0] pullup_ctl0;
        logic [ACC_W-1:0] file;
        logic mem_we;
        logic [DP_W-1:0] mem_addr;
        logic [ACC_W-1:0] mem_wdata;
        ato_op_e last_op;
        logic [7:0] op_count;
        logic [APB_DW-1:0] prdata;
        logic slverr;
    } ato_state_s;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    ato_state_s state_reg;
    ato_state_s state_next;
    logic setup;
    logic wr_access;
    logic mapped;
    logic [APB_DW-1:0] rd_word;
    logic is_store;
    logic op_wake;
    logic op_clk;
    logic op_pullup0;
    logic exec;

    // release reset through two flops
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    assign rst_n = rst_sync_reg[1];

    assign setup = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && PWRITE;
    assign exec = INSTR_VALID && state_reg.en;

    // decode of the covered opcodes; any other word passes through untouched
    always_comb
    begin
        op_wake = 1'b0;
        op_clk = 1'b0;
        op_pullup0 = 1'b0;
        is_store = 1'b0;
        if (INSTR == OP_LOAD_WAKE_CTL)
            op_wake = 1'b1;
        if (INSTR == OP_LOAD_CLK_CTL)
            op_clk = 1'b1;
        if (INSTR == OP_LOAD_PULLUP_CTL0)
            op_pullup0 = 1'b1;
        if ((INSTR & OP_STORE_MASK) == OP_STORE_MEM_XOR_FILE)
            is_store = 1'b1;
    end

    always_comb
    begin
        mapped = 1'b1;
        rd_word = '0;
        unique case (PADDR)
            OFS_CTRL:
                rd_word[CTRL_EN_BIT] = state_reg.en;
            OFS_WAKE:
                rd_word[ACC_W-1:0] = state_reg.wake_ctl;
            OFS_CLK:
                rd_word[ACC_W-1:0] = state_reg.clk_ctl;
            OFS_PULLUP0:
                rd_word[ACC_W-1:0] = state_reg.pullup_ctl0;
            OFS_FILE:
                rd_word[ACC_W-1:0] = state_reg.file;
            OFS_STATUS:
            begin
                rd_word[ST_LAST_LSB +: 3] = state_reg.last_op;
                rd_word[ST_COUNT_LSB +: 8] = state_reg.op_count;
            end
            default:
                mapped = 1'b0;
        endcase
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.mem_we = 1'b0;
        // read data captured in setup so the access phase needs no wait
        if (setup)
        begin
            state_next.prdata = PWRITE ? '0 : rd_word;
            state_next.slverr = !mapped;
        end
        // software writes first; an instruction in the same cycle wins
        if (wr_access)
        begin
            if (PADDR == OFS_CTRL)
                state_next.en = PWDATA[CTRL_EN_BIT];
            if (PADDR == OFS_FILE)
                state_next.file = PWDATA[ACC_W-1:0];
        end
        if (exec)
        begin
            if (op_wake)
            begin
                state_next.wake_ctl = ACC;
                state_next.last_op = ATO_OP_WAKE;
                state_next.op_count = state_reg.op_count + 8'h01;
            end
            else if (op_clk)
            begin
                state_next.clk_ctl = ACC;
                state_next.last_op = ATO_OP_CLK;
                state_next.op_count = state_reg.op_count + 8'h01;
            end
            else if (op_pullup0)
            begin
                state_next.pullup_ctl0 = ACC;
                state_next.last_op = ATO_OP_PULLUP0;
                state_next.op_count = state_reg.op_count + 8'h01;
            end
            else if (is_store)
            begin
                state_next.mem_we = 1'b1;
                state_next.mem_addr = DATA_POINTER;
                state_next.mem_wdata = ACC;
                state_next.file = state_reg.file ^ INSTR[IMM_LSB +: ACC_W];
                state_next.last_op = ATO_OP_STORE;
                state_next.op_count = state_reg.op_count + 8'h01;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.en <= RST_CTRL_EN;
            state_reg.wake_ctl <= RST_WAKE;
            state_reg.clk_ctl <= RST_CLK;
            state_reg.pullup_ctl0 <= RST_PULLUP0;
            state_reg.file <= RST_FILE;
            state_reg.mem_we <= 1'b0;
            state_reg.mem_addr <= '0;
            state_reg.mem_wdata <= '0;
            state_reg.last_op <= ATO_OP_NONE;
            state_reg.op_count <= '0;
            state_reg.prdata <= '0;
            state_reg.slverr <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign WAKE_CTL = state_reg.wake_ctl;
    assign CLK_CTL = state_reg.clk_ctl;
    assign PULLUP_CTL0 = state_reg.pullup_ctl0;
    assign FILE_REG = state_reg.file;
    assign MEM_WE = state_reg.mem_we;
    assign MEM_ADDR = state_reg.mem_addr;
    assign MEM_WDATA = state_reg.mem_wdata;
    assign PRDATA = state_reg.prdata;
    // zero wait states, since read data is already captured in setup
    assign PREADY = 1'b1;
    // error shown only in the access phase, where the master samples it
    assign PSLVERR = PSEL && PENABLE && state_reg.slverr;
endmodule : ato_core

/* File: bench/ato_core_props.sv */
// assertion checker for the accumulator transfer block
`timescale 1ns/10ps
module ato_core_chk
    import ato_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // instruction
    input wire logic INSTR_VALID,
    input wire logic [ato_pkg::OP_W-1:0] INSTR,
    input wire logic [ato_pkg::ACC_W-1:0] ACC,
    input wire logic [ato_pkg::DP_W-1:0] DATA_POINTER,
    // results
    input wire logic [ato_pkg::ACC_W-1:0] WAKE_CTL,
    input wire logic [ato_pkg::ACC_W-1:0] CLK_CTL,
    input wire logic [ato_pkg::ACC_W-1:0] PULLUP_CTL0,
    input wire logic [ato_pkg::ACC_W-1:0] FILE_REG,
    input wire logic [ato_pkg::ACC_W-1:0] MEM_WDATA,
    input wire logic MEM_WE,
    input wire logic [ato_pkg::DP_W-1:0] MEM_ADDR,
    // apb, only to follow the enable bit
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ato_pkg::APB_AW-1:0] PADDR,
    input wire logic [ato_pkg::APB_DW-1:0] PWDATA
);
    import ato_pkg::*;

    logic en_reg;
    // enable bit is internal, so mirror it from apb writes
    always_ff @(posedge CLK or negedge RESET_N)
        if (!RESET_N)
            en_reg <= RST_CTRL_EN;
        else if (PSEL && PENABLE && PWRITE && PADDR == OFS_CTRL)
            en_reg <= PWDATA[CTRL_EN_BIT];
    wire go = INSTR_VALID && en_reg;
    wire st = go && (INSTR & OP_STORE_MASK) == OP_STORE_MEM_XOR_FILE;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_store;
        st;
    endsequence
    a_wake_load: assert property (go && INSTR == OP_LOAD_WAKE_CTL |=> WAKE_CTL == $past(ACC))
        else $error("wake control not loaded");
    a_clk_load: assert property (go && INSTR == OP_LOAD_CLK_CTL |=> CLK_CTL == $past(ACC))
        else $error("clock control not loaded");
    a_pullup_load: assert property (go && INSTR == OP_LOAD_PULLUP_CTL0 |=>
        PULLUP_CTL0 == $past(ACC)) else $error("pull-up control not loaded");
    a_store_write: assert property (s_store |=> MEM_WE && MEM_ADDR == $past(DATA_POINTER)
        && MEM_WDATA == $past(ACC)) else $error("store write wrong");
    a_file_xor: assert property (s_store |=>
        FILE_REG == ($past(FILE_REG) ^ $past(INSTR[ACC_W-1:0]))) else $error("file xor wrong");
    a_we_cause: assert property (!st |=> !MEM_WE) else $error("stray ram write");
    a_wake_hold: assert property (!(go && INSTR == OP_LOAD_WAKE_CTL) |=> $stable(WAKE_CTL))
        else $error("wake control changed");
    a_clk_hold: assert property (!(go && INSTR == OP_LOAD_CLK_CTL) |=> $stable(CLK_CTL))
        else $error("clock control changed");
    a_pullup_hold: assert property (!(go && INSTR == OP_LOAD_PULLUP_CTL0) |=>
        $stable(PULLUP_CTL0)) else $error("pull-up control changed");
endmodule : ato_core_chk

bind ato_core ato_core_chk u_chk
(
    .CLK(CLK),
    .RESET_N(RESET_N),
    .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR),
    .ACC(ACC),
    .DATA_POINTER(DATA_POINTER),
    .WAKE_CTL(WAKE_CTL),
    .CLK_CTL(CLK_CTL),
    .PULLUP_CTL0(PULLUP_CTL0),
    .FILE_REG(FILE_REG),
    .MEM_WDATA(MEM_WDATA),
    .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA)
);

/* File: bench/testbench.sv */
// self-checking bench for the accumulator transfer block
`timescale 1ns/10ps
module testbench;
    import ato_pkg::*;
    logic CLK = 0, RESET_N = 0, INSTR_VALID = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [OP_W-1:0] INSTR = '0;
    logic [ACC_W-1:0] ACC = '0, WAKE_CTL, CLK_CTL, PULLUP_CTL0, FILE_REG, MEM_WDATA, f;
    logic [DP_W-1:0] DATA_POINTER = '0, MEM_ADDR;
    logic [APB_AW-1:0] PADDR = '0;
    logic [APB_DW-1:0] PWDATA = '0, PRDATA, rd;
    logic MEM_WE, PREADY, PSLVERR, er;
    int mismatches = 0, n_compared = 0;
    ato_core dut
    (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .INSTR_VALID(INSTR_VALID),
        .INSTR(INSTR),
        .ACC(ACC),
        .DATA_POINTER(DATA_POINTER),
        .WAKE_CTL(WAKE_CTL),
        .CLK_CTL(CLK_CTL),
        .PULLUP_CTL0(PULLUP_CTL0),
        .FILE_REG(FILE_REG),
        .MEM_WE(MEM_WE),
        .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR)
    );
    initial forever #2.5 CLK = ~CLK;
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // valid drops after each instruction; results are checked 1 ns after the edge that takes it, before the gap cycle
    task exec(input logic [9:0] op, input logic [3:0] a, input logic [7:0] p);
        @(posedge CLK);
        INSTR_VALID <= 1'b1;
        INSTR <= op;
        ACC <= a;
        DATA_POINTER <= p;
        @(posedge CLK);
        INSTR_VALID <= 1'b0;
        #1;
    endtask : exec
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude
    initial
    begin
        #20000;
        mismatches++;
        conclude;
    end
    initial
    begin
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        repeat (4) @(posedge CLK);
        for (int i = 0; i < 5; i++)
        begin
            apb(0, 8'(4 * i), 0);
            chk(rd, 32'(i == 0));
        end
        exec(OP_LOAD_WAKE_CTL, 4'h5, 8'h00);
        chk(WAKE_CTL, 4'h5);
        exec(OP_LOAD_CLK_CTL, 4'ha, 8'h00);
        chk(CLK_CTL, 4'ha);
        chk(WAKE_CTL, 4'h5);
        exec(OP_LOAD_PULLUP_CTL0, 4'h3, 8'h00);
        chk(PULLUP_CTL0, 4'h3);
        apb(0, OFS_CLK, 0);
        chk(rd, 32'h0000_000a);
        apb(1, OFS_FILE, 32'h0000_0006);
        f = 4'h6;
        for (int j = 0; j < 16; j++)
        begin
            exec(OP_STORE_MEM_XOR_FILE | 10'(j), 4'(15 - j), 8'(j * 17));
            f = f ^ 4'(j);
            chk(FILE_REG, f);
            chk({MEM_WE, MEM_ADDR, MEM_WDATA}, {1'b1, 8'(j * 17), 4'(15 - j)});
        end
        @(posedge CLK);
        #1;
        chk(MEM_WE, 0);
        apb(1, OFS_CTRL, 32'h0000_0000);
        exec(OP_LOAD_WAKE_CTL, 4'hf, 8'h00);
        chk(WAKE_CTL, 4'h5);
        apb(1, OFS_CTRL, 32'h0000_0001);
        exec(10'h217, 4'hf, 8'h00);
        chk(WAKE_CTL, 4'h5);
        apb(1, OFS_WAKE, 32'h0000_0009);
        apb(0, OFS_WAKE, 0);
        chk(rd, 32'h0000_0005);
        // nineteen transfers ran, the stores last
        apb(0, OFS_STATUS, 0);
        chk(rd, (32'h0000_0013 << ST_COUNT_LSB) | 32'(ATO_OP_STORE));
        apb(0, 8'h18, 0);
        chk(er, 1);
        chk(rd, 0);
        conclude;
    end
endmodule : testbench
